// ### core/dpic_ctrl.sv
// Two-level, eleven-source interrupt controller with fixed vectors.
//
// Functional notes
// - Enable bit 7 gates all maskable sources.
// - Enable bits 6..0 per primary source.
// - Primary priority bits 6..0, bit 7 reserved.
// - Secondary priority bits 6,5,4 for three sources.
// - Secondary enable bits 2,1,0 for three sources.
// - Reset values A0 and 00; no bit access.
// - High level may preempt low-level service.
// - High level wins over simultaneous low.
// - Same level never preempts a running routine.
// - Fixed polling order resolves same-level ties.
// - Push program counter, then load vector.
// - Vectors for externals, timers and serial.
// - Vectors for ADC, SPI, monitor, interval, watchdog.
// - Watchdog select turns timeout into interrupt.
// - Watchdog always runs at high level.
// - Global enable never blocks watchdog.
// - Watchdog interrupts only with nonzero timeout.
// - Main enable at A8, resets to 00.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

module dpic_ctrl
    import dpic_pkg::*;
(
    // Clock and reset.
    input  wire  logic                    ref_clk,
    input  wire  logic                    rst,
    // Register port.
    input  wire  logic [7:0]              reg_addr,
    input  wire  logic [7:0]              reg_wdata,
    input  wire  logic                    reg_wr,
    input  wire  logic                    reg_rd,
    output logic       [7:0]              reg_rdata,
    // Peripheral request flags, level sensitive.
    input  wire  logic                    supply_monitor_flag,
    input  wire  logic                    watchdog_timeout_flag,
    input  wire  logic                    watchdog_irq_select,
    input  wire  logic                    watchdog_timeout_nonzero,
    input  wire  logic                    ext0_request_flag,
    input  wire  logic                    primary_adc_ready,
    input  wire  logic                    aux_adc_ready,
    input  wire  logic                    timer0_overflow_flag,
    input  wire  logic                    ext1_request_flag,
    input  wire  logic                    timer1_overflow_flag,
    input  wire  logic                    twowire_irq_flag,
    input  wire  logic                    spi_irq_flag,
    input  wire  logic                    uart_rx_done_flag,
    input  wire  logic                    uart_tx_done_flag,
    input  wire  logic                    timer2_overflow_flag,
    input  wire  logic                    timer2_external_flag,
    input  wire  logic                    interval_counter_flag,
    // Processor core handshake.
    input  wire  logic [15:0]             core_pc,
    input  wire  logic                    core_boundary,
    input  wire  logic                    core_reti,
    output logic                          irq_pending,
    output logic                          call_push,
    output logic                          call_load,
    output dpic_call_type                 call_info,
    output logic                          watchdog_reset_req,
    output logic [1:0]                    in_service
);

    // =====================================================================
    // Storage
    // =====================================================================
    logic [7:0]              main_enable_r;   // Global and primary enables.
    logic [7:0]              prim_prio_r;     // Primary priority selections.
    logic [6:0]              sec_en_prio_r;   // Secondary bits 6..0.
    logic [7:0]              reg_rdata_r;     // Read data, one cycle late.
    logic                    hi_active_r;     // High-level routine running.
    logic                    lo_active_r;     // Low-level routine running.
    dpic_state_type          state_r;         // Call sequencer state.
    dpic_call_type           call_r;          // Call being performed.
    logic                    push_r;          // Push strobe to the core.
    logic                    load_r;          // Load strobe to the core.
    logic                    pending_r;       // Some request wins arbitration.
    logic                    wd_reset_r;      // Watchdog reset request.

    // =====================================================================
    // Request gathering
    // =====================================================================
    logic [DPIC_NUM_SRC-1:0] raw_req;         // Flags in polling order.
    logic [DPIC_NUM_SRC-1:0] enabled;         // Enable applied per source.
    logic [DPIC_NUM_SRC-1:0] high_sel;        // Source runs at high level.
    logic [DPIC_NUM_SRC-1:0] eligible;        // Passing all gates.
    logic [DPIC_NUM_SRC-1:0] hi_req;          // Eligible at high level.
    logic [DPIC_NUM_SRC-1:0] lo_req;          // Eligible at low level.
    logic                    global_en;       // Global maskable enable.

    // Shared-vector flags are merged into one request per vector.
    always_comb begin
        // Cleared first, then set per source.
        raw_req                = '0;
        raw_req[DPIC_SRC_PSM]  = supply_monitor_flag;
        raw_req[DPIC_SRC_WDOG] = watchdog_timeout_flag & watchdog_irq_select
                                 & watchdog_timeout_nonzero;
        raw_req[DPIC_SRC_EXT0] = ext0_request_flag;
        raw_req[DPIC_SRC_ADC]  = primary_adc_ready | aux_adc_ready;
        raw_req[DPIC_SRC_TMR0] = timer0_overflow_flag;
        raw_req[DPIC_SRC_EXT1] = ext1_request_flag;
        raw_req[DPIC_SRC_TMR1] = timer1_overflow_flag;
        raw_req[DPIC_SRC_SER]  = twowire_irq_flag | spi_irq_flag;
        raw_req[DPIC_SRC_UART] = uart_rx_done_flag | uart_tx_done_flag;
        raw_req[DPIC_SRC_TMR2] = timer2_overflow_flag | timer2_external_flag;
        raw_req[DPIC_SRC_TIC]  = interval_counter_flag;
    end

    // Each source except the watchdog is gated by its own enable and by the global one.
    always_comb begin
        global_en              = main_enable_r[DPIC_GLOBAL_EN_BIT];
        enabled                = '0;
        enabled[DPIC_SRC_PSM]  = global_en & sec_en_prio_r[DPIC_PSM_EN_BIT];
        enabled[DPIC_SRC_WDOG] = 1'b1;
        enabled[DPIC_SRC_EXT0] = global_en & main_enable_r[DPIC_EXT0_BIT];
        enabled[DPIC_SRC_ADC]  = global_en & main_enable_r[DPIC_ADC_BIT];
        enabled[DPIC_SRC_TMR0] = global_en & main_enable_r[DPIC_TIMER0_BIT];
        enabled[DPIC_SRC_EXT1] = global_en & main_enable_r[DPIC_EXT1_BIT];
        enabled[DPIC_SRC_TMR1] = global_en & main_enable_r[DPIC_TIMER1_BIT];
        enabled[DPIC_SRC_SER]  = global_en & sec_en_prio_r[DPIC_SERIAL_EN_BIT];
        enabled[DPIC_SRC_UART] = global_en & main_enable_r[DPIC_UART_BIT];
        enabled[DPIC_SRC_TMR2] = global_en & main_enable_r[DPIC_TIMER2_BIT];
        enabled[DPIC_SRC_TIC]  = global_en & sec_en_prio_r[DPIC_TIC_EN_BIT];
    end

    // Priority level of each source, one meaning high.
    always_comb begin
        high_sel                = '0;
        high_sel[DPIC_SRC_PSM]  = sec_en_prio_r[DPIC_PSM_PRIO_BIT];
        high_sel[DPIC_SRC_WDOG] = 1'b1;
        high_sel[DPIC_SRC_EXT0] = prim_prio_r[DPIC_EXT0_BIT];
        high_sel[DPIC_SRC_ADC]  = prim_prio_r[DPIC_ADC_BIT];
        high_sel[DPIC_SRC_TMR0] = prim_prio_r[DPIC_TIMER0_BIT];
        high_sel[DPIC_SRC_EXT1] = prim_prio_r[DPIC_EXT1_BIT];
        high_sel[DPIC_SRC_TMR1] = prim_prio_r[DPIC_TIMER1_BIT];
        high_sel[DPIC_SRC_SER]  = sec_en_prio_r[DPIC_SERIAL_PRIO_BIT];
        high_sel[DPIC_SRC_UART] = prim_prio_r[DPIC_UART_BIT];
        high_sel[DPIC_SRC_TMR2] = prim_prio_r[DPIC_TIMER2_BIT];
        high_sel[DPIC_SRC_TIC]  = sec_en_prio_r[DPIC_TIC_PRIO_BIT];
    end

    // A high request waits only for a high routine; a low one waits for any routine.
    always_comb begin
        // Flag and enable both needed.
        eligible = raw_req & enabled;
        hi_req   = (hi_active_r) ? '0 : (eligible & high_sel);
        lo_req   = (hi_active_r | lo_active_r) ? '0 : (eligible & ~high_sel);
    end

    // =====================================================================
    // Arbitration
    // =====================================================================
    logic [DPIC_NUM_SRC-1:0] level_req;       // Requests of the winning level.
    logic                    win_high;        // Winner is at high level.
    logic                    win_valid;       // Some request wins.
    logic [DPIC_NUM_SRC-1:0] win_onehot;      // Winning source, one-hot.
    logic [15:0]             win_vector;      // Vector of the winner.

    // High level is served first, then the lowest polling index within it.
    always_comb begin
        win_high   = |hi_req;
        level_req  = win_high ? hi_req : lo_req;
        win_valid  = |level_req;
        // Defaults when nothing wins.
        win_onehot = '0;
        win_vector = '0;
        for (int i = DPIC_NUM_SRC - 1; i >= 0; i--) begin
            // Lower index written last, so it wins.
            if (level_req[i]) begin
                win_onehot    = '0;
                win_onehot[i] = 1'b1;
                win_vector    = DPIC_VECTOR[i];
            end
        end
    end

    // =====================================================================
    // Register writes
    // =====================================================================
    // Main enable register holds plain read-write bits.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            main_enable_r <= DPIC_MAIN_ENABLE_RST;
        end else if (reg_wr && reg_addr == DPIC_MAIN_ENABLE_ADDR) begin
            // Whole byte replaced.
            main_enable_r <= reg_wdata;
        end
    end

    // Primary priority register; the reserved bit always stays zero.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prim_prio_r <= DPIC_PRIM_PRIO_RST;
        end else if (reg_wr && reg_addr == DPIC_PRIM_PRIO_ADDR) begin
            // Reserved bit cleared below.
            prim_prio_r                     <= reg_wdata;
            prim_prio_r[DPIC_PRIM_RSVD_BIT] <= 1'b0;
        end
    end

    // Secondary register; bit 3 is held at zero whatever software writes.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sec_en_prio_r <= DPIC_SEC_EN_PRIO_RST[6:0];
        end else if (reg_wr && reg_addr == DPIC_SEC_EN_PRIO_ADDR) begin
            // Top bit is not stored.
            sec_en_prio_r                       <= reg_wdata[6:0];
            sec_en_prio_r[DPIC_SEC_RSVD_LO_BIT] <= 1'b0;
        end
    end

    // =====================================================================
    // Register reads
    // =====================================================================
    // Read data appears in the cycle after the read strobe; unmapped reads give zero.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Bus reads zero in reset.
            reg_rdata_r <= DPIC_UNMAPPED_RDATA;
        end else if (reg_rd) begin
            case (reg_addr)
                DPIC_MAIN_ENABLE_ADDR: begin
                    // Stored byte as written.
                    reg_rdata_r <= main_enable_r;
                end
                DPIC_PRIM_PRIO_ADDR: begin
                    // Reserved bit reads zero.
                    reg_rdata_r <= prim_prio_r;
                end
                DPIC_SEC_EN_PRIO_ADDR: begin
                    // Reserved top bit reads as one.
                    reg_rdata_r <= {DPIC_SEC_RSVD_HI_VAL, sec_en_prio_r};
                end
                default: begin
                    // Unmapped address reads zero.
                    reg_rdata_r <= DPIC_UNMAPPED_RDATA;
                end
            endcase
        end else begin
            // Data stands one cycle only.
            reg_rdata_r <= DPIC_UNMAPPED_RDATA;
        end
    end

    // =====================================================================
    // Call sequencer
    // =====================================================================
    // Idle waits for a winner at an instruction boundary, then pushes and loads.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // No call in flight.
            state_r <= DPIC_ST_IDLE;
            call_r  <= '0;
            push_r  <= 1'b0;
            load_r  <= 1'b0;
        end else begin
            // Strobes are one-cycle pulses.
            push_r <= 1'b0;
            load_r <= 1'b0;
            case (state_r)
                DPIC_ST_IDLE: begin
                    // Winner is frozen here so later flag changes cannot alter the call.
                    if (win_valid && core_boundary) begin
                        call_r.push_pc    <= core_pc;
                        call_r.vector     <= win_vector;
                        call_r.high_level <= win_high;
                        call_r.taken_src  <= win_onehot;
                        push_r            <= 1'b1;
                        state_r           <= DPIC_ST_PUSH;
                    end
                end
                DPIC_ST_PUSH: begin
                    load_r  <= 1'b1;
                    state_r <= DPIC_ST_LOAD;
                end
                DPIC_ST_LOAD: begin
                    // Call done; may accept again.
                    state_r <= DPIC_ST_IDLE;
                end
                default: begin
                    // Unused code returns to idle.
                    state_r <= DPIC_ST_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // In-service tracking
    // =====================================================================
    // A return ends the highest running level; a new call sets its level and
    // is written last so that a set in the same cycle wins over the clear.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Nothing in service.
            hi_active_r <= 1'b0;
            lo_active_r <= 1'b0;
        end else begin
            if (core_reti) begin
                // Highest running level ends.
                if (hi_active_r) begin
                    hi_active_r <= 1'b0;
                end else begin
                    lo_active_r <= 1'b0;
                end
            end

            if (state_r == DPIC_ST_IDLE && win_valid && core_boundary) begin
                if (win_high) begin
                    hi_active_r <= 1'b1;
                end else begin
                    lo_active_r <= 1'b1;
                end
            end
        end
    end

    // =====================================================================
    // Status outputs
    // =====================================================================
    // Pending shows a request that wins arbitration; the watchdog reset request fires when
    // a timeout arrives while the watchdog interrupt select is low.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Quiet after reset.
            pending_r  <= 1'b0;
            wd_reset_r <= 1'b0;
        end else begin
            // Arbiter result, one cycle late.
            pending_r  <= win_valid;
            wd_reset_r <= watchdog_timeout_flag & ~watchdog_irq_select;
        end
    end

    // Outputs come straight from flip-flops.
    assign reg_rdata          = reg_rdata_r;
    assign irq_pending        = pending_r;
    assign call_push          = push_r;
    assign call_load          = load_r;
    assign call_info          = call_r;
    assign watchdog_reset_req = wd_reset_r;
    assign in_service         = {hi_active_r, lo_active_r};

endmodule // dpic_ctrl

// ### include/dpic_pkg.sv
// Constants, types and register map of the two-level interrupt controller.
package dpic_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    // Special-function addresses of the three controller registers.
    localparam logic [7:0] DPIC_MAIN_ENABLE_ADDR  = 8'h0A8;
    localparam logic [7:0] DPIC_SEC_EN_PRIO_ADDR  = 8'h0A9;
    localparam logic [7:0] DPIC_PRIM_PRIO_ADDR    = 8'h0B8;

    // Power-on values of the registers.
    localparam logic [7:0] DPIC_MAIN_ENABLE_RST   = 8'h00;
    localparam logic [7:0] DPIC_SEC_EN_PRIO_RST   = 8'hA0;
    localparam logic [7:0] DPIC_PRIM_PRIO_RST     = 8'h00;

    // Value returned for an address that holds no register.
    localparam logic [7:0] DPIC_UNMAPPED_RDATA    = 8'h00;

    // =====================================================================
    // Field positions
    // =====================================================================
    // Main enable register.
    localparam int DPIC_GLOBAL_EN_BIT  = 7;
    localparam int DPIC_ADC_BIT        = 6;
    localparam int DPIC_TIMER2_BIT     = 5;
    localparam int DPIC_UART_BIT       = 4;
    localparam int DPIC_TIMER1_BIT     = 3;
    localparam int DPIC_EXT1_BIT       = 2;
    localparam int DPIC_TIMER0_BIT     = 1;
    localparam int DPIC_EXT0_BIT       = 0;
    // Primary priority register reserved bit.
    localparam int DPIC_PRIM_RSVD_BIT  = 7;
    // Secondary enable and priority register.
    localparam int DPIC_SEC_RSVD_HI_BIT   = 7;
    localparam int DPIC_TIC_PRIO_BIT      = 6;
    localparam int DPIC_PSM_PRIO_BIT      = 5;
    localparam int DPIC_SERIAL_PRIO_BIT   = 4;
    localparam int DPIC_SEC_RSVD_LO_BIT   = 3;
    localparam int DPIC_TIC_EN_BIT        = 2;
    localparam int DPIC_PSM_EN_BIT        = 1;
    localparam int DPIC_SERIAL_EN_BIT     = 0;
    // Reserved bit 7 of the secondary register reads back as one.
    localparam logic DPIC_SEC_RSVD_HI_VAL = 1'b1;

    // =====================================================================
    // Sources in polling order, index 0 is polled first
    // =====================================================================
    localparam int DPIC_NUM_SRC  = 11;
    localparam int DPIC_SRC_PSM  = 0;
    localparam int DPIC_SRC_WDOG = 1;
    localparam int DPIC_SRC_EXT0 = 2;
    localparam int DPIC_SRC_ADC  = 3;
    localparam int DPIC_SRC_TMR0 = 4;
    localparam int DPIC_SRC_EXT1 = 5;
    localparam int DPIC_SRC_TMR1 = 6;
    localparam int DPIC_SRC_SER  = 7;
    localparam int DPIC_SRC_UART = 8;
    localparam int DPIC_SRC_TMR2 = 9;
    localparam int DPIC_SRC_TIC  = 10;

    // Vector address of each source, listed in polling order.
    localparam logic [15:0] DPIC_VECTOR [DPIC_NUM_SRC] = '{
        16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
        16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053
    };

    // =====================================================================
    // Types
    // =====================================================================
    // Call sequencer states.
    typedef enum logic [1:0] {
        DPIC_ST_IDLE = 2'b00,
        DPIC_ST_PUSH = 2'b01,
        DPIC_ST_LOAD = 2'b10
    } dpic_state_type;

    // Everything the core needs to perform one interrupt call.
    typedef struct packed {
        logic [15:0]             push_pc;    // Program counter to push.
        logic [15:0]             vector;     // Address to load afterwards.
        logic                    high_level; // Call runs at the high level.
        logic [DPIC_NUM_SRC-1:0] taken_src;  // One-hot source being served.
    } dpic_call_type;

endpackage

// ### tb/dpic_ctrl_properties.sv
// Port checks of the interrupt controller.
`timescale 1ns/1ps
module dpic_ctrl_properties
    import dpic_pkg::*;
(
    // Clock, reset and read path.
    input wire logic          ref_clk, rst, reg_rd,
    input wire logic [7:0]    reg_rdata,
    // Core handshake.
    input wire logic [15:0]   core_pc,
    input wire logic          core_boundary, core_reti, call_push, call_load,
    input wire dpic_call_type call_info,
    input wire logic [1:0]    in_service,
    // Watchdog path.
    input wire logic          watchdog_timeout_flag, watchdog_irq_select, watchdog_reset_req
);
    // =====================================================================
    // Checks, all in the core clock domain.
    // =====================================================================
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    push_then_load_a: assert property (call_push |=> call_load ##1 !call_load)
        else $error("load did not follow push");
    call_gap_a: assert property (call_push |=> !call_push ##1 !call_push)
        else $error("calls too close");
    pushed_pc_a: assert property (call_push |-> call_info.push_pc == $past(core_pc))
        else $error("wrong pushed pc");
    at_boundary_a: assert property (call_push |-> $past(core_boundary))
        else $error("call without boundary");
    low_blocked_a: assert property (call_push && !call_info.high_level |->
        $past(in_service) == 2'b00)
        else $error("low call during service");
    high_blocked_a: assert property (call_push && call_info.high_level |->
        !$past(in_service[1]))
        else $error("high call during high service");
    level_set_a: assert property (call_push |-> in_service[call_info.high_level])
        else $error("level not marked");
    return_clear_a: assert property (core_reti && in_service != 2'b00 |=> call_push ||
        in_service == ($past(in_service[1]) ? {1'b0, $past(in_service[0])} : 2'b00))
        else $error("return did not clear level");
    one_source_a: assert property (call_push |-> $onehot(call_info.taken_src))
        else $error("taken source not one-hot");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside slot");
    wdog_reset_a: assert property (!$past(rst) |-> watchdog_reset_req ==
        ($past(watchdog_timeout_flag) && !$past(watchdog_irq_select)))
        else $error("wrong watchdog reset");
endmodule // dpic_ctrl_properties

bind dpic_ctrl dpic_ctrl_properties u_props (.ref_clk, .rst, .reg_rd, .reg_rdata, .core_pc,
    .core_boundary, .core_reti, .call_push, .call_load, .call_info, .in_service,
    .watchdog_timeout_flag, .watchdog_irq_select, .watchdog_reset_req);

// ### tb/dpic_core_model.sv
// Behavioural processor core answering interrupt calls.
`timescale 1ns/1ps
module dpic_core_model
    import dpic_pkg::*;
(
    // Clock, reset and bench control.
    input  wire logic          ref_clk, rst, go,
    // Call strobes from the controller.
    input  wire logic          call_push, call_load,
    input  wire dpic_call_type call_info,
    // Core state seen by the controller.
    output logic      [15:0]   core_pc,
    output logic               core_boundary
);
    // The program counter steps each cycle and jumps on a load.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            core_pc <= 16'h1000;
        end else if (call_load) begin
            core_pc <= call_info.vector;
        end else begin
            core_pc <= core_pc + 16'h0001;
        end
    end
    // No boundary while a call is in flight.
    assign core_boundary = go & ~call_push & ~call_load;
endmodule // dpic_core_model

// ### tb/dpic_ctrl_tb.sv
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ps
module dpic_ctrl_tb;
    import dpic_pkg::*;
    logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, core_reti = 0, go = 0, alt = 0;
    logic wd_sel = 1, wd_nz = 1, core_boundary, call_push, call_load, irq_pending, wd_rst;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [10:0] flg = 11'h000;
    logic [15:0] core_pc;
    logic [1:0] in_service;
    dpic_call_type call_info;
    int bad_count = 0, n_compared = 0, cyc = 0;
    // Expected vector of each source, in polling order.
    logic [15:0] vec [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
        16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
    always #5 ref_clk = ~ref_clk;
    dpic_ctrl uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .supply_monitor_flag(flg[0]), .watchdog_timeout_flag(flg[1]),
        .watchdog_irq_select(wd_sel), .watchdog_timeout_nonzero(wd_nz),
        .ext0_request_flag(flg[2]), .primary_adc_ready(flg[3] & ~alt),
        .aux_adc_ready(flg[3] & alt), .timer0_overflow_flag(flg[4]),
        .ext1_request_flag(flg[5]), .timer1_overflow_flag(flg[6]),
        .twowire_irq_flag(flg[7] & ~alt), .spi_irq_flag(flg[7] & alt),
        .uart_rx_done_flag(flg[8] & ~alt), .uart_tx_done_flag(flg[8] & alt),
        .timer2_overflow_flag(flg[9] & ~alt), .timer2_external_flag(flg[9] & alt),
        .interval_counter_flag(flg[10]), .core_pc, .core_boundary, .core_reti,
        .irq_pending, .call_push, .call_load, .call_info, .watchdog_reset_req(wd_rst),
        .in_service);
    dpic_core_model core (.ref_clk, .rst, .go, .call_push, .call_load, .call_info,
        .core_pc, .core_boundary);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1 chk(call_push, 1'b0);
        end
    endtask
    task automatic reti();
        @(posedge ref_clk) core_reti <= 1'b1;
        @(posedge ref_clk) core_reti <= 1'b0;
    endtask
    // Waits for one call and checks its vector, level and source.
    task automatic take(input int i, input logic hi);
        int n;
        n = 0;
        while (call_push !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(call_push, 1'b1);
        chk(irq_pending, 1'b1);
        chk(call_info.vector, vec[i]);
        chk(call_info.high_level, hi);
        chk(call_info.taken_src, 16'h0001 << i);
        @(posedge ref_clk) flg[i] <= 1'b0;
    endtask
    task automatic t_regs();
        rd(8'hA8, 8'h00);
        rd(8'hA9, 8'hA0);
        rd(8'hB8, 8'h00);
        wr(8'hB8, 8'hFF);
        rd(8'hB8, 8'h7F);
        wr(8'hA9, 8'h77);
        rd(8'hA9, 8'hF7);
        wr(8'hB9, 8'h55);
        rd(8'hB9, 8'h00);
        wr(8'hA8, 8'h7F);
        rd(8'hA8, 8'h7F);
    endtask
    task automatic t_mask();
        @(posedge ref_clk) {go, flg} <= {1'b1, 11'h004};
        idle(20);
        chk(irq_pending, 1'b0);
        @(posedge ref_clk) flg[1] <= 1'b1;
        take(1, 1'b1);
        reti();
        @(posedge ref_clk) {wd_nz, flg[1]} <= 2'b01;
        idle(10);
        @(posedge ref_clk) {wd_nz, wd_sel} <= 2'b10;
        idle(3);
        chk(wd_rst, 1'b1);
        @(posedge ref_clk) {wd_sel, flg} <= {1'b1, 11'h000};
    endtask
    task automatic t_poll();
        wr(8'hB8, 8'h00);
        wr(8'hA9, 8'h07);
        wr(8'hA8, 8'hFF);
        for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk) {alt, flg} <= {p[0], 11'h7FF};
            take(1, 1'b1);
            reti();
            for (int i = 0; i < 11; i++) begin
                if (i != 1) begin
                    take(i, 1'b0);
                    reti();
                end
            end
        end
    endtask
    task automatic t_preempt();
        wr(8'hB8, 8'h02);
        @(posedge ref_clk) flg <= 11'h004;
        take(2, 1'b0);
        @(posedge ref_clk) flg <= 11'h030;
        take(4, 1'b1);
        idle(8);
        chk(irq_pending, 1'b0);
        chk(in_service, 2'b11);
        reti();
        idle(5);
        reti();
        take(5, 1'b0);
        reti();
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_mask();
        t_poll();
        t_preempt();
        results();
    end
endmodule // dpic_ctrl_tb
